// File: chg_ctrl.sv
// Charger input qualification, input interrupt and precharge state control.
// Assumes comparator levels from the analog front end and an 8-bit register port.
//
// Overview of operation
// - Input valid only when above undervoltage, below overvoltage and above system rail margin.
// - Rail margin choice between 50 mV and 175 mV comes from a programmed strap.
// - Any change of the qualified input status raises the input interrupt.
// - Input valid and input sense bits are readable status.
// - Input interrupt output is held off while its mask bit is set.
// - Input below undervoltage level counts as source removed regardless of others.
// - Self-discharge load is off in low-power mode and on otherwise.
// - Enter precharge while battery is below low-battery threshold selected by bits 6:5.
// - After deglitch time in precharge raise charger interrupt, set ok, clear sense.
// - Battery rising above the low-battery threshold moves precharge to fast charge.
// - Exceeding the precharge time limit moves the machine to timer fault.
// - Host kicks the watchdog; expiry during precharge moves to watchdog suspend.
// - System-minimum codes 00, 01, 10 give 3.5, 3.7, 4.3 V; 11 is reserved.
// - Regulation register holds system-minimum in bits 7:6, charge voltage in 5:0.
// - Trickle current chosen between 55 mA and 100 mA from battery voltage.
`timescale 1ns/1ps
`default_nettype none
module chg_ctrl
	import chg_pkg::*;
#(
	parameter logic [39:0] DEGLITCH_CYC = 40'(CHG_DEGLITCH_CYC),
	parameter logic [39:0] PRECHG_LIMIT_CYC = 40'(CHG_PRECHG_LIMIT_CYC),
	parameter logic [39:0] WDOG_TIMEOUT_CYC = 40'(CHG_WDOG_TIMEOUT_CYC)
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic input_above_uvlo,
	input wire logic input_below_ovlo,
	input wire logic input_above_rail_50,
	input wire logic input_above_rail_175,
	input wire logic otp_margin_175,
	input wire logic batt_below_low_thr,
	input wire logic batt_above_trickle_lvl,
	input wire logic low_power_mode,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic input_irq,
	output logic charger_irq,
	output logic source_removed,
	output logic self_discharge_en,
	output logic trickle_current_hi,
	output logic [1:0] low_batt_threshold_sel,
	output logic [5:0] charge_voltage_sel,
	output logic [12:0] system_minimum_mv,
	output logic system_minimum_reserved,
	output logic [4:0] charge_state
);

	// ==========================================================
	// Input synchronisation
	logic [6:0] raw_in;
	logic [6:0] syn;
	assign raw_in = {low_power_mode, batt_above_trickle_lvl, batt_below_low_thr, otp_margin_175,
		input_above_rail_175, input_above_rail_50, input_below_ovlo};
	logic uvlo_s;
	chg_sync #(.W(8)) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.async_in({raw_in, input_above_uvlo}),
		.sync_out({syn, uvlo_s})
	);
	logic ovlo_s, m50_s, m175_s, otp_s, batt_low_s, trk_s, lp_s;
	assign {lp_s, trk_s, batt_low_s, otp_s, m175_s, m50_s, ovlo_s} = syn;

	// ==========================================================
	// Margin strap captured once after reset release
	logic strap_done_r;
	logic [1:0] strap_wait_r;
	logic margin_175_r;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			strap_done_r <= 1'b0;
			strap_wait_r <= 2'b00;
			margin_175_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_wait_r <= {strap_wait_r[0], 1'b1};
			if (strap_wait_r[1]) begin
				strap_done_r <= 1'b1;
				margin_175_r <= otp_s;
			end
		end
	end

	// ==========================================================
	// Input qualification
	logic input_valid;
	logic rail_ok;
	assign rail_ok = margin_175_r ? m175_s : m50_s;
	assign input_valid = strap_done_r && uvlo_s && ovlo_s && rail_ok;
	assign source_removed = !uvlo_s;
	assign self_discharge_en = !lp_s;
	assign trickle_current_hi = trk_s;

	logic valid_r;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= input_valid;
		end
	end
	logic valid_change;
	assign valid_change = strap_done_r && (valid_r != input_valid);

	// ==========================================================
	// Configuration registers
	logic [7:0] regv_r;
	logic [7:0] cur_ctrl_r;
	logic mask_r;
	logic wr_regv, wr_cur, wr_mask, wr_in_irq, wr_chg_irq, wr_kick;
	assign wr_regv = reg_wr && (reg_addr == CHG_ADDR_BATT_REG_VOLT);
	assign wr_cur = reg_wr && (reg_addr == CHG_ADDR_CURRENT_CTRL);
	assign wr_mask = reg_wr && (reg_addr == CHG_ADDR_INPUT_MASK);
	assign wr_in_irq = reg_wr && (reg_addr == CHG_ADDR_INPUT_IRQ);
	assign wr_chg_irq = reg_wr && (reg_addr == CHG_ADDR_CHG_IRQ);
	assign wr_kick = reg_wr && (reg_addr == CHG_ADDR_WDOG_KICK);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			regv_r <= CHG_RST_BATT_REG_VOLT;
			cur_ctrl_r <= CHG_RST_CURRENT_CTRL;
			mask_r <= CHG_RST_INPUT_MASK[CHG_BIT_IRQ];
		end else begin
			if (wr_regv) begin
				regv_r <= reg_wdata;
			end
			if (wr_cur) begin
				cur_ctrl_r <= {1'b0, reg_wdata[6:0]};
			end
			if (wr_mask) begin
				mask_r <= reg_wdata[CHG_BIT_IRQ];
			end
		end
	end
	assign low_batt_threshold_sel = cur_ctrl_r[CHG_LB_THR_HI:CHG_LB_THR_LO];
	assign charge_voltage_sel = regv_r[CHG_CV_HI:CHG_CV_LO];

	// System-minimum decode
	always_comb begin
		system_minimum_reserved = 1'b0;
		case (regv_r[CHG_SYSMIN_HI:CHG_SYSMIN_LO])
			2'b00: system_minimum_mv = CHG_SYSMIN_MV_00;
			2'b01: system_minimum_mv = CHG_SYSMIN_MV_01;
			2'b10: system_minimum_mv = CHG_SYSMIN_MV_10;
			default: begin
				system_minimum_mv = CHG_SYSMIN_MV_10;
				system_minimum_reserved = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Watchdog
	logic [39:0] wd_cnt_r;
	logic wd_expired;
	assign wd_expired = (wd_cnt_r >= WDOG_TIMEOUT_CYC);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wd_cnt_r <= 40'h00_0000_0000;
		end else if (wr_kick) begin
			wd_cnt_r <= 40'h00_0000_0000;
		end else if (!wd_expired) begin
			wd_cnt_r <= wd_cnt_r + 40'h00_0000_0001;
		end
	end

	// ==========================================================
	// Charge state machine
	chg_state_type state_r, state_nxt;
	logic [39:0] dg_cnt_r;
	logic [39:0] pt_cnt_r;
	logic dg_done_r;
	logic in_prechg;
	logic dg_fire;
	logic pt_over;
	assign in_prechg = (state_r == CHG_ST_PRECHG);
	assign dg_fire = in_prechg && !dg_done_r && (dg_cnt_r == DEGLITCH_CYC - 40'h00_0000_0001);
	assign pt_over = (pt_cnt_r >= PRECHG_LIMIT_CYC);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CHG_ST_IDLE: begin
				if (input_valid) begin
					state_nxt = batt_low_s ? CHG_ST_PRECHG : CHG_ST_FAST_CC;
				end
			end
			CHG_ST_PRECHG: begin
				if (!input_valid) begin
					state_nxt = CHG_ST_IDLE;
				end else if (wd_expired) begin
					state_nxt = CHG_ST_WDOG_SUSP;
				end else if (pt_over) begin
					state_nxt = CHG_ST_TIMER_FAULT;
				end else if (!batt_low_s) begin
					state_nxt = CHG_ST_FAST_CC;
				end
			end
			CHG_ST_FAST_CC, CHG_ST_TIMER_FAULT, CHG_ST_WDOG_SUSP: begin
				if (!input_valid) begin
					state_nxt = CHG_ST_IDLE;
				end
			end
			default: state_nxt = CHG_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= CHG_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end
	assign charge_state = state_r;

	// Precharge counters
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dg_cnt_r <= 40'h00_0000_0000;
			pt_cnt_r <= 40'h00_0000_0000;
			dg_done_r <= 1'b0;
		end else if (!in_prechg) begin
			dg_cnt_r <= 40'h00_0000_0000;
			pt_cnt_r <= 40'h00_0000_0000;
			dg_done_r <= 1'b0;
		end else begin
			if (!dg_done_r) begin
				dg_cnt_r <= dg_cnt_r + 40'h00_0000_0001;
			end
			if (dg_fire) begin
				dg_done_r <= 1'b1;
			end
			if (!pt_over) begin
				pt_cnt_r <= pt_cnt_r + 40'h00_0000_0001;
			end
		end
	end

	// ==========================================================
	// Status and interrupt flags
	logic in_pend_r, chg_pend_r, charger_ok_status_r;
	logic [7:0] chg_sense_r;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			in_pend_r <= 1'b0;
			chg_pend_r <= 1'b0;
			charger_ok_status_r <= 1'b0;
			chg_sense_r <= CHG_SENSE_PRECHG;
		end else begin
			in_pend_r <= (in_pend_r && !(wr_in_irq && reg_wdata[CHG_BIT_IRQ])) || valid_change;
			chg_pend_r <= (chg_pend_r && !(wr_chg_irq && reg_wdata[CHG_BIT_IRQ])) || dg_fire;
			if (dg_fire) begin
				charger_ok_status_r <= 1'b1;
				chg_sense_r <= CHG_SENSE_PRECHG;
			end else if (!input_valid) begin
				charger_ok_status_r <= 1'b0;
			end
		end
	end
	assign input_irq = in_pend_r && !mask_r;
	assign charger_irq = chg_pend_r;

	// ==========================================================
	// Register read port
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				CHG_ADDR_INPUT_STATUS: reg_rdata <= {6'h00, uvlo_s, valid_r};
				CHG_ADDR_INPUT_IRQ: reg_rdata <= {7'h00, in_pend_r};
				CHG_ADDR_INPUT_MASK: reg_rdata <= {7'h00, mask_r};
				CHG_ADDR_CHG_IRQ: reg_rdata <= {7'h00, chg_pend_r};
				CHG_ADDR_CHG_STATUS: reg_rdata <= {7'h00, charger_ok_status_r};
				CHG_ADDR_CHG_SENSE: reg_rdata <= chg_sense_r;
				CHG_ADDR_CURRENT_CTRL: reg_rdata <= cur_ctrl_r;
				CHG_ADDR_BATT_REG_VOLT: reg_rdata <= regv_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Assertions
	sequence s_prechg_held;
		in_prechg && !dg_done_r && dg_cnt_r == DEGLITCH_CYC - 40'h00_0000_0001;
	endsequence

	a_valid_qualify: assert property (@(posedge sys_clk) disable iff (!resetn)
		input_valid |-> uvlo_s && ovlo_s && (margin_175_r ? m175_s : m50_s))
		else $error("Input valid without all three conditions");
	a_margin_strap: assert property (@(posedge sys_clk) disable iff (!resetn)
		strap_done_r |=> $stable(margin_175_r))
		else $error("Margin selection changed after capture");
	a_change_irq: assert property (@(posedge sys_clk) disable iff (!resetn)
		(strap_done_r && $changed(input_valid)) |=> in_pend_r)
		else $error("Input status change did not raise interrupt");
	a_mask_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
		mask_r |-> !input_irq)
		else $error("Masked input interrupt delivered");
	a_removed_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
		(source_removed && state_r != CHG_ST_IDLE) |=> state_r == CHG_ST_IDLE)
		else $error("Removed source did not return machine to idle");
	a_self_disch: assert property (@(posedge sys_clk) disable iff (!resetn)
		self_discharge_en == !lp_s)
		else $error("Self-discharge load wrong for power mode");
	a_prechg_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_r == CHG_ST_IDLE && input_valid && batt_low_s) |=> in_prechg)
		else $error("Precharge not entered on low battery");
	a_deglitch_status: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_prechg_held |=> chg_pend_r && charger_ok_status_r && chg_sense_r == CHG_SENSE_PRECHG)
		else $error("Deglitch expiry did not update charger status");
	a_fast_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
		(in_prechg && input_valid && !wd_expired && !pt_over && !batt_low_s) |=> state_r == CHG_ST_FAST_CC)
		else $error("Precharge did not advance to fast charge");
	a_timer_fault: assert property (@(posedge sys_clk) disable iff (!resetn)
		(in_prechg && input_valid && !wd_expired && pt_over) |=> state_r == CHG_ST_TIMER_FAULT)
		else $error("Precharge time limit did not fault");
	a_wdog_susp: assert property (@(posedge sys_clk) disable iff (!resetn)
		(in_prechg && input_valid && wd_expired) |=> state_r == CHG_ST_WDOG_SUSP)
		else $error("Watchdog expiry did not suspend");
	a_counter_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
		(in_prechg ##1 !in_prechg) |=> dg_cnt_r == 40'h00_0000_0000 && pt_cnt_r == 40'h00_0000_0000)
		else $error("Precharge counters not cleared on exit");

endmodule
`default_nettype wire

// File: chg_pkg.sv
// Constants for the charger input qualification and precharge control block.
// Assumes a 100 MHz device clock and an 8-bit internal register port.
package chg_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] CHG_ADDR_INPUT_STATUS = 8'h80;
	localparam logic [7:0] CHG_ADDR_INPUT_IRQ = 8'h81;
	localparam logic [7:0] CHG_ADDR_INPUT_MASK = 8'h82;
	localparam logic [7:0] CHG_ADDR_CHG_IRQ = 8'h83;
	localparam logic [7:0] CHG_ADDR_CHG_STATUS = 8'h84;
	localparam logic [7:0] CHG_ADDR_CHG_SENSE = 8'h85;
	localparam logic [7:0] CHG_ADDR_WDOG_KICK = 8'h86;
	localparam logic [7:0] CHG_ADDR_CURRENT_CTRL = 8'h8E;
	localparam logic [7:0] CHG_ADDR_BATT_REG_VOLT = 8'h8F;

	// ==========================================================
	// Field positions
	localparam int CHG_BIT_INPUT_VALID = 0;
	localparam int CHG_BIT_INPUT_SENSE = 1;
	localparam int CHG_BIT_IRQ = 0;
	localparam int CHG_BIT_CHARGER_OK_STATUS = 0;
	localparam int CHG_LB_THR_HI = 6;
	localparam int CHG_LB_THR_LO = 5;
	localparam int CHG_SYSMIN_HI = 7;
	localparam int CHG_SYSMIN_LO = 6;
	localparam int CHG_CV_HI = 5;
	localparam int CHG_CV_LO = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] CHG_RST_BATT_REG_VOLT = 8'h2B;
	localparam logic [7:0] CHG_RST_CURRENT_CTRL = 8'h00;
	localparam logic [7:0] CHG_RST_INPUT_MASK = 8'h00;
	localparam logic [7:0] CHG_SENSE_PRECHG = 8'h00;

	// ==========================================================
	// System-minimum decode in millivolts
	localparam logic [12:0] CHG_SYSMIN_MV_00 = 13'h0DAC;
	localparam logic [12:0] CHG_SYSMIN_MV_01 = 13'h0E74;
	localparam logic [12:0] CHG_SYSMIN_MV_10 = 13'h10CC;

	// ==========================================================
	// Timing
	localparam longint CHG_CLK_HZ = 100_000_000;
	localparam longint CHG_DEGLITCH_MS = 32;
	localparam longint CHG_PRECHG_LIMIT_MIN = 30;
	localparam longint CHG_WDOG_TIMEOUT_S = 80;
	localparam longint CHG_DEGLITCH_CYC = CHG_DEGLITCH_MS * CHG_CLK_HZ / 1000;
	localparam longint CHG_PRECHG_LIMIT_CYC = CHG_PRECHG_LIMIT_MIN * 60 * CHG_CLK_HZ;
	localparam longint CHG_WDOG_TIMEOUT_CYC = CHG_WDOG_TIMEOUT_S * CHG_CLK_HZ;

	// ==========================================================
	// Charge state machine
	typedef enum logic [4:0] {
		CHG_ST_IDLE = 5'b00001,
		CHG_ST_PRECHG = 5'b00010,
		CHG_ST_FAST_CC = 5'b00100,
		CHG_ST_TIMER_FAULT = 5'b01000,
		CHG_ST_WDOG_SUSP = 5'b10000
	} chg_state_type;

endpackage

// File: chg_sync.sv
// Two-flop synchroniser bank for comparator and strap inputs.
// Assumes each input bit is an independent level.
`timescale 1ns/1ps
`default_nettype none
module chg_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ==========================================================
	// One synchroniser per bit
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_r;
			logic sync_r;
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else begin
					meta_r <= async_in[i];
					sync_r <= meta_r;
				end
			end
			assign sync_out[i] = sync_r;
		end
	endgenerate

endmodule
`default_nettype wire

// File: chg_host_model.sv
// Host processor model on the internal register port.
// Assumes the bench calls its tasks; drives pins at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module chg_host_model
	import chg_pkg::*;
(
	input wire logic sys_clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// ==========================================
	// Bus cycles
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask

	// Periodic watchdog service
	task automatic kick();
		wr(CHG_ADDR_WDOG_KICK, 8'h01);
	endtask

	// Preferred system-minimum setting, code 10
	task automatic set_sysmin_pref(input logic [5:0] cv);
		wr(CHG_ADDR_BATT_REG_VOLT, {2'b10, cv});
	endtask
endmodule
`default_nettype wire

// File: chg_ctrl_tb.sv
// Self-checking bench for the charger control block.
// Assumes short timing parameters and the host model.
`timescale 1ns/1ps
`default_nettype none
module chg_ctrl_tb;
	import chg_pkg::*;
	logic sys_clk = 1'b0, resetn = 1'b0;
	logic uvlo = 0, ovlo = 0, r50 = 0, r175 = 0, otp = 0, blow = 0, trk = 0, lpm = 0;
	logic [7:0] addr, wdata, rdata, d;
	logic wr, rd, iirq, cirq, srem, sden, trhi, smres;
	logic [1:0] lbsel;
	logic [5:0] cvsel;
	logic [12:0] smmv;
	logic [4:0] st;
	int fail_count = 0, comparisons = 0, n;
	typedef struct {logic u, o, m, l, t; logic [1:0] s; logic q;} row_type;
	row_type rows[6] = '{'{1,1,1,0,0,2'b11,1}, '{1,1,0,1,1,2'b10,1}, '{1,0,1,0,1,2'b10,0},
		'{0,1,1,1,0,2'b00,0}, '{1,1,1,1,1,2'b11,1}, '{0,1,1,0,0,2'b00,1}};
	logic [12:0] mv[4] = '{CHG_SYSMIN_MV_00, CHG_SYSMIN_MV_01, CHG_SYSMIN_MV_10, CHG_SYSMIN_MV_10};

	always #5 sys_clk = ~sys_clk;

	chg_ctrl #(.DEGLITCH_CYC(40'd8), .PRECHG_LIMIT_CYC(40'd64), .WDOG_TIMEOUT_CYC(40'd200)) i_dut (
		.sys_clk(sys_clk), .resetn(resetn), .input_above_uvlo(uvlo), .input_below_ovlo(ovlo),
		.input_above_rail_50(r50), .input_above_rail_175(r175), .otp_margin_175(otp),
		.batt_below_low_thr(blow), .batt_above_trickle_lvl(trk), .low_power_mode(lpm),
		.reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
		.input_irq(iirq), .charger_irq(cirq), .source_removed(srem), .self_discharge_en(sden),
		.trickle_current_hi(trhi), .low_batt_threshold_sel(lbsel), .charge_voltage_sel(cvsel),
		.system_minimum_mv(smmv), .system_minimum_reserved(smres), .charge_state(st));

	chg_host_model i_host (.sys_clk(sys_clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wdata), .reg_rdata(rdata));

	// ==========================================
	// Helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	task automatic do_reset();
		@(negedge sys_clk);
		resetn = 1'b0;
		cyc(5);
		resetn = 1'b1;
	endtask

	task automatic pins(input logic u, input logic v, input logic b);
		@(negedge sys_clk);
		uvlo = u;
		ovlo = v;
		r50 = v;
		r175 = v;
		blow = b;
		cyc(6);
	endtask

	task automatic enter_pre(input int idle);
		i_host.kick();
		pins(0, 0, 1);
		cyc(idle);
		pins(1, 1, 1);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#400000;
		fail_count++;
		tally_and_finish();
	end

	// ==========================================
	// Tests
	initial begin
		do_reset();
		i_host.rd(CHG_ADDR_BATT_REG_VOLT, d);
		chk(d, 8'h2B);
		chk(smmv, CHG_SYSMIN_MV_00);
		chk({srem, sden, st}, 7'h61);
		$display("reset test done");
		foreach (rows[i]) begin
			@(negedge sys_clk);
			{uvlo, ovlo, r50, lpm, trk} = {rows[i].u, rows[i].o, rows[i].m, rows[i].l, rows[i].t};
			cyc(6);
			chk({srem, sden, trhi}, {~rows[i].u, ~rows[i].l, rows[i].t});
			chk(iirq, rows[i].q);
			i_host.rd(CHG_ADDR_INPUT_STATUS, d);
			chk(d, {6'h00, rows[i].s});
			i_host.wr(CHG_ADDR_INPUT_IRQ, 8'h01);
		end
		$display("row test done");
		i_host.wr(CHG_ADDR_INPUT_MASK, 8'h01);
		pins(1, 1, 0);
		chk(iirq, 1'b0);
		i_host.rd(CHG_ADDR_INPUT_IRQ, d);
		chk(d, 8'h01);
		i_host.wr(CHG_ADDR_INPUT_MASK, 8'h00);
		cyc(1);
		chk(iirq, 1'b1);
		i_host.wr(CHG_ADDR_INPUT_IRQ, 8'h01);
		$display("mask test done");
		for (int c = 0; c < 4; c++) begin
			i_host.wr(CHG_ADDR_BATT_REG_VOLT, {c[1:0], 6'h15});
			cyc(1);
			chk({smres, smmv}, {c == 3, mv[c]});
			chk(cvsel, 6'h15);
		end
		i_host.set_sysmin_pref(6'h2B);
		i_host.rd(CHG_ADDR_BATT_REG_VOLT, d);
		chk(d, 8'hAB);
		i_host.wr(CHG_ADDR_CURRENT_CTRL, 8'hE0);
		i_host.rd(CHG_ADDR_CURRENT_CTRL, d);
		chk({d, lbsel}, {8'h60, 2'b11});
		$display("config test done");
		enter_pre(2);
		chk(st, CHG_ST_PRECHG);
		chk(cirq, 1'b0);
		cyc(4);
		chk(cirq, 1'b0);
		cyc(1);
		chk(cirq, 1'b1);
		i_host.rd(CHG_ADDR_CHG_STATUS, d);
		chk(d, 8'h01);
		i_host.rd(CHG_ADDR_CHG_SENSE, d);
		chk(d, CHG_SENSE_PRECHG);
		i_host.wr(CHG_ADDR_CHG_IRQ, 8'h01);
		pins(1, 1, 0);
		chk(st, CHG_ST_FAST_CC);
		$display("precharge test done");
		enter_pre(2);
		n = 6;
		while (st === CHG_ST_PRECHG && n < 100) begin
			cyc(1);
			n++;
		end
		chk(st, CHG_ST_TIMER_FAULT);
		chk(16'(n), 16'h0044);
		$display("time limit test done");
		enter_pre(170);
		chk(st, CHG_ST_PRECHG);
		cyc(40);
		chk(st, CHG_ST_WDOG_SUSP);
		$display("watchdog test done");
		otp = 1'b1;
		do_reset();
		@(negedge sys_clk);
		{uvlo, ovlo, r50, r175} = 4'b1110;
		cyc(6);
		i_host.rd(CHG_ADDR_INPUT_STATUS, d);
		chk(d, 8'h02);
		pins(1, 1, 0);
		i_host.rd(CHG_ADDR_INPUT_STATUS, d);
		chk(d, 8'h03);
		$display("margin test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
